// [rtl/tem_pkg.sv]
// constants, types and helpers shared by the trap and emulation mode control block
package tem_pkg;

  // ----------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------
  localparam int DATA_W = 16;
  localparam int ADDR_W = 20;

  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [11:0] OFF_CMD        = 12'h000;
  localparam logic [11:0] OFF_STATUS     = 12'h004;
  localparam logic [11:0] OFF_FLAGS      = 12'h008;
  localparam logic [11:0] OFF_CODE_SEG   = 12'h00C;
  localparam logic [11:0] OFF_INSTR_PTR  = 12'h010;
  localparam logic [11:0] OFF_STACK_PTR  = 12'h014;
  localparam logic [11:0] OFF_FRAME_PTR  = 12'h018;
  localparam logic [11:0] OFF_DATA_SEG0  = 12'h01C;
  localparam logic [11:0] OFF_STACK_SEG  = 12'h020;
  localparam logic [11:0] OFF_ESC_EA     = 12'h024;
  localparam logic [11:0] OFF_FETCH_ADDR = 12'h028;
  localparam logic [11:0] OFF_DATA_ADDR  = 12'h02C;
  localparam logic [11:0] OFF_STACK_ADDR = 12'h030;

  // ----------------------------------------------------------------
  // fields
  // ----------------------------------------------------------------
  localparam int FLAG_BRK = 8;
  localparam int FLAG_IE  = 9;
  localparam int FLAG_V   = 11;
  localparam int FLAG_MD  = 15;
  localparam logic [15:0] FLAGS_RST = 16'h8000;

  localparam int CMD_OP_LSB  = 0;
  localparam int CMD_VEC_LSB = 8;

  localparam int ST_BUSY    = 0;
  localparam int ST_NATIVE  = 1;
  localparam int ST_STANDBY = 2;
  localparam int ST_HOLD    = 3;
  localparam int ST_ERR     = 4;
  localparam int ST_PEND    = 5;

  // ----------------------------------------------------------------
  // command codes
  // ----------------------------------------------------------------
  localparam logic [3:0] OP_DIV_ERR   = 4'h0;
  localparam logic [3:0] OP_BOUNDS    = 4'h1;
  localparam logic [3:0] OP_OVF_BRK   = 4'h2;
  localparam logic [3:0] OP_BRK_ONE   = 4'h3;
  localparam logic [3:0] OP_BRK_TWO   = 4'h4;
  localparam logic [3:0] OP_ENTER_EMU = 4'h5;
  localparam logic [3:0] OP_NCALL     = 4'h6;
  localparam logic [3:0] OP_LEAVE_EMU = 4'h7;
  localparam logic [3:0] OP_TRAP_RET  = 4'h8;
  localparam logic [3:0] OP_HALT      = 4'h9;
  localparam logic [3:0] OP_ESC_A     = 4'hA;
  localparam logic [3:0] OP_ESC_B     = 4'hB;

  // ----------------------------------------------------------------
  // vectors and addressing
  // ----------------------------------------------------------------
  localparam logic [7:0]  VEC_DIVIDE   = 8'h00;
  localparam logic [7:0]  VEC_BRK_FLAG = 8'h01;
  localparam logic [7:0]  VEC_NMI      = 8'h02;
  localparam logic [7:0]  VEC_ONE_BYTE = 8'h03;
  localparam logic [7:0]  VEC_OVF      = 8'h04;
  localparam logic [7:0]  VEC_BOUNDS   = 8'h05;
  localparam logic [7:0]  VEC_GEN_MIN  = 8'h20;
  localparam logic [19:0] VEC_BASE_HI  = 20'h00002;
  localparam logic [15:0] STACK_STEP   = 16'h0002;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {K_PLAIN, K_ENTER, K_NATIVE, K_LEAVE, K_TRET} tem_kind_t;
  typedef enum logic [2:0] {A_NONE, A_TRAP, A_POP, A_HALT, A_ESC, A_DONE, A_REFUSE} tem_act_t;

  typedef struct packed {
    logic              req;
    logic              we;
    logic              escape;
    logic              esc_b;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } tem_mem_t;

  function automatic logic [ADDR_W-1:0] phys(input logic [15:0] seg, input logic [15:0] off);
    phys = {seg, 4'h0} + {4'h0, off};
  endfunction

endpackage

// [rtl/tem_ctrl.sv]
// trap entry/return sequencer, emulation mode flag, standby and apb register file

// Operation
// RL1 - enter emulation: push frame, clear mode, vector
// RL2 - emulation stack pointer is frame pointer
// RL3 - emulation never touches native regs, segments
// RL4 - fetch uses code segment, data uses segment zero
// RL5 - software never nests enter emulation
// RL6 - leave emulation pops frame, sets native mode
// RL7 - native call pushes frame, sets native mode
// RL8 - trap return pops; mode from restored flags
// RL9 - trap return also ends interrupts from emulation
// RL10 - escape: address and read only, data ignored
// RL11 - coprocessor snoops fetches and read cycle
// RL12 - nonmaskable input and enable-gated maskable input
// RL13 - software trap sources raise their vectors
// RL14 - vector table 256 four-byte entries at zero
// RL15 - general vectors only from thirty-two upward
// RL16 - low word to pointer, high word to segment
// RL17 - entry order: vector, flags, segment, pointer
// RL18 - halt enters standby, core clock gated
// RL19 - reset or interrupt ends standby
// RL20 - standby still grants bus hold
// RL21 - standby disables controls, bus held static
// RL22 - top 256 i/o bytes stay unused
// RL23 - mode flag one native, zero emulation
// RL24 - reset and interrupts force native mode
// RL25 - vector address is number times four
module tem_ctrl (
  // clock and reset
  input  wire logic             pclk,
  input  wire logic             presetn,
  // apb slave
  input  wire logic             psel,
  input  wire logic             penable,
  input  wire logic             pwrite,
  input  wire logic [11:0]      paddr,
  input  wire logic [31:0]      pwdata,
  output logic      [31:0]      prdata,
  output logic                  pready,
  output logic                  pslverr,
  // memory master
  output tem_pkg::tem_mem_t     mem_o,
  input  wire logic [15:0]      mem_rdata,
  input  wire logic             mem_ack,
  // pins
  input  wire logic             nmi,
  input  wire logic             int_req,
  input  wire logic [7:0]       int_vector,
  input  wire logic             hold_req,
  output logic                  hold_ack,
  // core status
  output logic                  native_mode,
  output logic                  core_clk_en,
  output logic                  bus_ctrl_en
);

  typedef enum logic [3:0] {
    S_IDLE, S_VEC_LO, S_VEC_HI, S_PUSH_FL, S_PUSH_CS, S_PUSH_IP,
    S_POP_IP, S_POP_CS, S_POP_FL, S_ESC_RD, S_STANDBY
  } tem_state_t;

  tem_state_t          state;
  tem_pkg::tem_kind_t  kind;
  tem_pkg::tem_kind_t  next_kind;
  tem_pkg::tem_act_t   next_act;
  logic [7:0]          next_vec;
  logic                next_esc_b;
  logic                next_from_cmd;

  logic [15:0] flags_word, code_segment, instr_pointer, stack_ptr, frame_ptr;
  logic [15:0] data_segment_zero, stack_seg, esc_ea, temp_offset, temp_base;
  logic [7:0]  vec;
  logic        esc_b;
  logic [3:0]  cmd_op;
  logic [7:0]  cmd_vec;
  logic        cmd_pend, err, nmi_pend, nmi_seen;
  logic [10:0] sync1, sync2;
  logic        nmi_s, int_s, hold_s, nmi_edge;
  logic [7:0]  int_vec_s;
  logic        apb_wr, apb_ok, err_clr, cmd_wr;
  logic        mem_state, st_we;
  logic [19:0] st_addr;
  logic [15:0] st_wdata;
  logic [31:0] rd_mux;

  localparam int CMD_OP_MSB  = tem_pkg::CMD_OP_LSB + 3;
  localparam int CMD_VEC_MSB = tem_pkg::CMD_VEC_LSB + 7;

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1 <= '0;
      sync2 <= '0;
    end else begin
      sync1 <= {hold_req, int_req, nmi, int_vector};
      sync2 <= sync1;
    end
  end

  assign int_vec_s = sync2[7:0];
  assign nmi_s     = sync2[8];
  assign int_s     = sync2[9];
  assign hold_s    = sync2[10];
  assign nmi_edge  = nmi_s & ~nmi_seen;

  // ----------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------
  always_comb begin
    apb_ok = 1'b1;
    rd_mux = '0;
    case (paddr)
      tem_pkg::OFF_CMD:        rd_mux = {16'h0000, cmd_vec, 4'h0, cmd_op};
      tem_pkg::OFF_STATUS: begin
        rd_mux[tem_pkg::ST_BUSY]    = (state != S_IDLE) && (state != S_STANDBY);
        rd_mux[tem_pkg::ST_NATIVE]  = flags_word[tem_pkg::FLAG_MD];
        rd_mux[tem_pkg::ST_STANDBY] = (state == S_STANDBY);
        rd_mux[tem_pkg::ST_HOLD]    = hold_ack;
        rd_mux[tem_pkg::ST_ERR]     = err;
        rd_mux[tem_pkg::ST_PEND]    = cmd_pend;
      end
      tem_pkg::OFF_FLAGS:      rd_mux = {16'h0000, flags_word};
      tem_pkg::OFF_CODE_SEG:   rd_mux = {16'h0000, code_segment};
      tem_pkg::OFF_INSTR_PTR:  rd_mux = {16'h0000, instr_pointer};
      tem_pkg::OFF_STACK_PTR:  rd_mux = {16'h0000, stack_ptr};
      tem_pkg::OFF_FRAME_PTR:  rd_mux = {16'h0000, frame_ptr};
      tem_pkg::OFF_DATA_SEG0:  rd_mux = {16'h0000, data_segment_zero};
      tem_pkg::OFF_STACK_SEG:  rd_mux = {16'h0000, stack_seg};
      tem_pkg::OFF_ESC_EA:     rd_mux = {16'h0000, esc_ea};
      // RL4 fetch address
      tem_pkg::OFF_FETCH_ADDR: rd_mux = {12'h000, tem_pkg::phys(code_segment, instr_pointer)};
      // RL4 data address
      tem_pkg::OFF_DATA_ADDR:  rd_mux = {12'h000, tem_pkg::phys(data_segment_zero, esc_ea)};
      // RL2 active stack
      tem_pkg::OFF_STACK_ADDR: rd_mux = {12'h000, tem_pkg::phys(stack_seg,
                                         flags_word[tem_pkg::FLAG_MD] ? stack_ptr : frame_ptr)};
      default:                 apb_ok = 1'b0;
    endcase
  end

  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~apb_ok;
  assign apb_wr  = psel & penable & pwrite & apb_ok;
  assign err_clr = apb_wr && (paddr == tem_pkg::OFF_STATUS) && pwdata[tem_pkg::ST_ERR];
  assign cmd_wr  = apb_wr && (paddr == tem_pkg::OFF_CMD);

  // read data is sampled in the setup phase so the access phase answers at once
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= '0;
    end else if (psel && !penable && !pwrite) begin
      prdata <= rd_mux;
    end
  end

  // ----------------------------------------------------------------
  // next action when idle
  // ----------------------------------------------------------------
  always_comb begin
    next_act      = tem_pkg::A_NONE;
    next_vec      = '0;
    next_kind     = tem_pkg::K_PLAIN;
    next_esc_b    = 1'b0;
    next_from_cmd = 1'b0;
    // RL12 nonmaskable first
    if (nmi_pend) begin
      next_act  = tem_pkg::A_TRAP;
      next_vec  = tem_pkg::VEC_NMI;
      next_kind = tem_pkg::K_NATIVE;
    // RL13 break flag trap
    end else if (flags_word[tem_pkg::FLAG_BRK]) begin
      next_act = tem_pkg::A_TRAP;
      next_vec = tem_pkg::VEC_BRK_FLAG;
    // RL12 maskable, RL15 general vectors only
    end else if (int_s && flags_word[tem_pkg::FLAG_IE] && (int_vec_s >= tem_pkg::VEC_GEN_MIN)) begin
      next_act  = tem_pkg::A_TRAP;
      next_vec  = int_vec_s;
      next_kind = tem_pkg::K_NATIVE;
    end else if (cmd_pend) begin
      next_from_cmd = 1'b1;
      next_act      = tem_pkg::A_TRAP;
      next_vec      = cmd_vec;
      // RL13 software sources
      case (cmd_op)
        tem_pkg::OP_DIV_ERR:  next_vec = tem_pkg::VEC_DIVIDE;
        tem_pkg::OP_BOUNDS:   next_vec = tem_pkg::VEC_BOUNDS;
        tem_pkg::OP_BRK_ONE:  next_vec = tem_pkg::VEC_ONE_BYTE;
        tem_pkg::OP_BRK_TWO:  next_vec = cmd_vec;
        tem_pkg::OP_OVF_BRK: begin
          next_vec = tem_pkg::VEC_OVF;
          if (!flags_word[tem_pkg::FLAG_V]) next_act = tem_pkg::A_DONE;
        end
        // RL1 native only; RL5 nesting refused; RL15 vector range
        tem_pkg::OP_ENTER_EMU: begin
          next_kind = tem_pkg::K_ENTER;
          if (!flags_word[tem_pkg::FLAG_MD] || cmd_vec < tem_pkg::VEC_GEN_MIN) next_act = tem_pkg::A_REFUSE;
        end
        // RL7 emulation only; RL15 vector range
        tem_pkg::OP_NCALL: begin
          next_kind = tem_pkg::K_NATIVE;
          if (flags_word[tem_pkg::FLAG_MD] || cmd_vec < tem_pkg::VEC_GEN_MIN) next_act = tem_pkg::A_REFUSE;
        end
        // RL6 decoded only in emulation
        tem_pkg::OP_LEAVE_EMU: begin
          next_kind = tem_pkg::K_LEAVE;
          next_act  = flags_word[tem_pkg::FLAG_MD] ? tem_pkg::A_REFUSE : tem_pkg::A_POP;
        end
        tem_pkg::OP_TRAP_RET: begin
          next_kind = tem_pkg::K_TRET;
          next_act  = tem_pkg::A_POP;
        end
        // RL18 halt from either mode
        tem_pkg::OP_HALT:     next_act = tem_pkg::A_HALT;
        tem_pkg::OP_ESC_A:    next_act = tem_pkg::A_ESC;
        tem_pkg::OP_ESC_B: begin
          next_act   = tem_pkg::A_ESC;
          next_esc_b = 1'b1;
        end
        default:              next_act = tem_pkg::A_REFUSE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // memory cycle of the current state
  // ----------------------------------------------------------------
  always_comb begin
    mem_state = 1'b1;
    st_we     = 1'b0;
    st_wdata  = '0;
    st_addr   = tem_pkg::phys(stack_seg, stack_ptr);
    case (state)
      // RL14 RL25 table at zero, entry times four, offset word first
      S_VEC_LO:  st_addr = {10'h000, vec, 2'b00};
      S_VEC_HI:  st_addr = {10'h000, vec, 2'b00} + tem_pkg::VEC_BASE_HI;
      // RL2 trap frames always go to the native stack
      S_PUSH_FL: begin
        st_we    = 1'b1;
        st_addr  = tem_pkg::phys(stack_seg, stack_ptr - tem_pkg::STACK_STEP);
        st_wdata = flags_word;
      end
      S_PUSH_CS: begin
        st_we    = 1'b1;
        st_addr  = tem_pkg::phys(stack_seg, stack_ptr - tem_pkg::STACK_STEP);
        st_wdata = code_segment;
      end
      S_PUSH_IP: begin
        st_we    = 1'b1;
        st_addr  = tem_pkg::phys(stack_seg, stack_ptr - tem_pkg::STACK_STEP);
        st_wdata = instr_pointer;
      end
      S_POP_IP, S_POP_CS, S_POP_FL: st_addr = tem_pkg::phys(stack_seg, stack_ptr);
      // RL4 RL10 escape read at data segment zero
      S_ESC_RD:  st_addr = tem_pkg::phys(data_segment_zero, esc_ea);
      default:   mem_state = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // sequencer and architectural state
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state             <= S_IDLE;
      kind              <= tem_pkg::K_PLAIN;
      // RL24 RL23 reset leaves the core native
      flags_word        <= tem_pkg::FLAGS_RST;
      code_segment      <= '0;
      instr_pointer     <= '0;
      stack_ptr         <= '0;
      frame_ptr         <= '0;
      data_segment_zero <= '0;
      stack_seg         <= '0;
      esc_ea            <= '0;
      temp_offset       <= '0;
      temp_base         <= '0;
      vec               <= '0;
      esc_b             <= 1'b0;
      cmd_op            <= '0;
      cmd_vec           <= '0;
      cmd_pend          <= 1'b0;
      err               <= 1'b0;
      nmi_pend          <= 1'b0;
      nmi_seen          <= 1'b0;
      mem_o             <= '0;
    end else begin
      nmi_seen <= nmi_s;
      if (err_clr) err <= 1'b0;
      case (state)
        S_IDLE: if (!hold_ack) begin
          // software may load the register set only while nothing is in flight
          if (apb_wr) begin
            case (paddr)
              tem_pkg::OFF_FLAGS:     flags_word        <= pwdata[15:0];
              tem_pkg::OFF_CODE_SEG:  code_segment      <= pwdata[15:0];
              tem_pkg::OFF_INSTR_PTR: instr_pointer     <= pwdata[15:0];
              tem_pkg::OFF_STACK_PTR: stack_ptr         <= pwdata[15:0];
              tem_pkg::OFF_FRAME_PTR: frame_ptr         <= pwdata[15:0];
              tem_pkg::OFF_DATA_SEG0: data_segment_zero <= pwdata[15:0];
              tem_pkg::OFF_STACK_SEG: stack_seg         <= pwdata[15:0];
              tem_pkg::OFF_ESC_EA:    esc_ea            <= pwdata[15:0];
              default: ;
            endcase
          end
          if (next_from_cmd) cmd_pend <= 1'b0;
          if (next_act == tem_pkg::A_TRAP && next_kind == tem_pkg::K_NATIVE && !next_from_cmd) begin
            nmi_pend <= 1'b0;
          end
          vec   <= next_vec;
          kind  <= next_kind;
          esc_b <= next_esc_b;
          case (next_act)
            tem_pkg::A_TRAP:   state <= S_VEC_LO;
            tem_pkg::A_POP:    state <= S_POP_IP;
            tem_pkg::A_ESC:    state <= S_ESC_RD;
            tem_pkg::A_HALT:   state <= S_STANDBY;
            tem_pkg::A_REFUSE: err   <= 1'b1;
            default: ;
          endcase
        end
        // RL19 interrupt request wakes; RL20 not while hold is granted
        S_STANDBY: if (!hold_ack && (nmi_pend || int_s)) begin
          state <= S_IDLE;
        end
        default: if (mem_state) begin
          if (!mem_o.req) begin
            mem_o <= '{req: 1'b1, we: st_we, escape: (state == S_ESC_RD), esc_b: esc_b,
                       addr: st_addr, wdata: st_wdata};
          end else if (mem_ack) begin
            mem_o <= '0;
            case (state)
              // RL16 RL17 offset and base into temporaries
              S_VEC_LO: begin
                temp_offset <= mem_rdata;
                state       <= S_VEC_HI;
              end
              S_VEC_HI: begin
                temp_base <= mem_rdata;
                state     <= S_PUSH_FL;
              end
              // RL17 flags pushed, then enable and break cleared
              S_PUSH_FL: begin
                stack_ptr                       <= stack_ptr - tem_pkg::STACK_STEP;
                flags_word[tem_pkg::FLAG_IE]    <= 1'b0;
                flags_word[tem_pkg::FLAG_BRK]   <= 1'b0;
                // RL1 enter emulation clears mode
                if (kind == tem_pkg::K_ENTER) flags_word[tem_pkg::FLAG_MD] <= 1'b0;
                // RL7 RL24 native call and interrupts force native
                if (kind == tem_pkg::K_NATIVE) flags_word[tem_pkg::FLAG_MD] <= 1'b1;
                state <= S_PUSH_CS;
              end
              // RL16 base to code segment
              S_PUSH_CS: begin
                stack_ptr    <= stack_ptr - tem_pkg::STACK_STEP;
                code_segment <= temp_base;
                state        <= S_PUSH_IP;
              end
              // RL16 offset to instruction pointer
              S_PUSH_IP: begin
                stack_ptr     <= stack_ptr - tem_pkg::STACK_STEP;
                instr_pointer <= temp_offset;
                state         <= S_IDLE;
              end
              S_POP_IP: begin
                stack_ptr     <= stack_ptr + tem_pkg::STACK_STEP;
                instr_pointer <= mem_rdata;
                state         <= S_POP_CS;
              end
              S_POP_CS: begin
                stack_ptr    <= stack_ptr + tem_pkg::STACK_STEP;
                code_segment <= mem_rdata;
                state        <= S_POP_FL;
              end
              // RL8 RL9 restored mode bit selects decoding
              S_POP_FL: begin
                stack_ptr  <= stack_ptr + tem_pkg::STACK_STEP;
                flags_word <= mem_rdata;
                // RL6 leave emulation always lands native
                if (kind == tem_pkg::K_LEAVE) flags_word[tem_pkg::FLAG_MD] <= 1'b1;
                state <= S_IDLE;
              end
              // RL10 returned data deliberately dropped
              default: state <= S_IDLE;
            endcase
          end
        end else begin
          state <= S_IDLE;
        end
      endcase
      // a command written while another waits is refused
      if (cmd_wr) begin
        if (cmd_pend) begin
          err <= 1'b1;
        end else begin
          cmd_pend <= 1'b1;
          cmd_op   <= pwdata[CMD_OP_MSB:tem_pkg::CMD_OP_LSB];
          cmd_vec  <= pwdata[CMD_VEC_MSB:tem_pkg::CMD_VEC_LSB];
        end
      end
      // new edge wins over the acceptance clear
      if (nmi_edge) nmi_pend <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // bus hold, standby gating and status outputs
  // ----------------------------------------------------------------
  // RL20 hold granted only between sequences, so no access is cut short
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hold_ack <= 1'b0;
    end else if (!hold_s) begin
      hold_ack <= 1'b0;
    end else if ((state == S_IDLE || state == S_STANDBY) && !mem_o.req) begin
      hold_ack <= 1'b1;
    end
  end

  // RL18 RL21 core clock gated and controls off in standby
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      core_clk_en <= 1'b1;
      bus_ctrl_en <= 1'b1;
      native_mode <= 1'b1;
    end else begin
      core_clk_en <= (state != S_STANDBY);
      bus_ctrl_en <= (state != S_STANDBY) && !hold_ack;
      // RL23 mode flag drives decoding
      native_mode <= flags_word[tem_pkg::FLAG_MD];
    end
  end

  // RL3 no path here writes source, destination, accumulator or other segments;
  // emulation code reaches only the frame pointer as its stack

endmodule // tem_ctrl

// [test/tem_mem_model.sv]
// memory with vector table pattern and coprocessor snoop
module tem_mem_model (
  input  wire logic              pclk,
  input  wire tem_pkg::tem_mem_t mem_o,
  output logic [15:0]            mem_rdata,
  output logic                   mem_ack,
  output logic [19:0]            snoop_addr
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [15:0] m [logic [19:0]];
  initial begin
    mem_ack = 1'h0;
    mem_rdata = 16'h0000;
    snoop_addr = 20'h00000;
  end
  always @(posedge pclk) begin
    mem_ack <= mem_o.req && !mem_ack;
    mem_rdata <= ~mem_rdata;
    if (mem_o.req && !mem_ack) begin
      if (mem_o.we) m[mem_o.addr] = mem_o.wdata;
      mem_rdata <= m.exists(mem_o.addr) ? m[mem_o.addr] : mem_o.addr[15:0] ^ 16'h5A5A;
      if (mem_o.escape) snoop_addr <= mem_o.addr;
    end
  end
endmodule // tem_mem_model

// [test/tem_ctrl_properties.sv]
// concurrent checks on the trap and emulation control ports
module tem_ctrl_props (
  input wire logic              pclk,
  input wire logic              presetn,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pslverr,
  input wire tem_pkg::tem_mem_t mem_o,
  input wire logic              mem_ack,
  input wire logic              nmi,
  input wire logic              hold_req,
  input wire logic              hold_ack,
  input wire logic              native_mode,
  input wire logic              core_clk_en,
  input wire logic              bus_ctrl_en
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  chk_req_held: assert property (mem_o.req && !mem_ack |=> mem_o.req && $stable(mem_o.addr))
    else $error("memory request dropped early");
  chk_esc_read: assert property (mem_o.req && mem_o.escape |-> !mem_o.we)
    else $error("escape cycle is not a read");
  chk_stby_ctrl: assert property (!core_clk_en |-> !bus_ctrl_en)
    else $error("controls live in standby");
  chk_hold_bus: assert property (hold_ack |-> !bus_ctrl_en)
    else $error("controls live while hold granted");
  chk_stby_grant: assert property ($rose(hold_req) && !core_clk_en |-> ##[1:6] hold_ack)
    else $error("hold not granted in standby");
  chk_nmi_wake: assert property ($rose(nmi) && !core_clk_en |-> ##[1:6] core_clk_en)
    else $error("standby not left on nmi");
  chk_nmi_native: assert property ($rose(nmi) && !native_mode |-> ##[1:60] native_mode)
    else $error("nmi left emulation mode set");
  chk_err_phase: assert property (pslverr |-> psel && penable)
    else $error("error outside access phase");
endmodule // tem_ctrl_props
bind tem_ctrl tem_ctrl_props u_props (.pclk, .presetn, .psel, .penable, .pslverr, .mem_o, .mem_ack, .nmi,
  .hold_req, .hold_ack, .native_mode, .core_clk_en, .bus_ctrl_en);

// [test/trap_and_emulation_mode_control_tb.sv]
// self-checking bench for the trap and emulation mode control block
module trap_and_emulation_mode_control_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0, nmi = 1'h0, hold_req = 1'h0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, r;
  logic pready, pslverr, mem_ack, hold_ack, native_mode, core_clk_en, bus_ctrl_en;
  logic [15:0] mem_rdata;
  logic [19:0] snoop_addr;
  tem_pkg::tem_mem_t mem_o;
  int fails = 0, compares = 0;
  always #2.5 pclk = ~pclk;
  tem_ctrl uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .mem_o,
    .mem_rdata, .mem_ack, .nmi, .int_req(1'h0), .int_vector(8'h00), .hold_req, .hold_ack, .native_mode,
    .core_clk_en, .bus_ctrl_en);
  tem_mem_model u_mem (.pclk, .mem_o, .mem_rdata, .mem_ack, .snoop_addr);
  task automatic stop_test;
    if (fails == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    do @(posedge pclk); while (pready !== 1'h1);
    q = prdata;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task automatic rd(input string n, input logic [11:0] a, input logic [15:0] e);
    apb(1'h0, a, 32'h0, r);
    chk(n, r, {16'h0, e});
  endtask
  // wait on the busy bit, bounded
  task automatic cmd(input logic [3:0] op, input logic [7:0] v);
    apb(1'h1, tem_pkg::OFF_CMD, {16'h0, v, 4'h0, op}, r);
    r = 32'h1;
    for (int i = 0; i < 30 && r[0] !== 1'h0; i++) apb(1'h0, tem_pkg::OFF_STATUS, 32'h0, r);
  endtask
  task automatic nm(input string n, input logic e);
    chk(n, {31'h0, native_mode}, {31'h0, e});
  endtask
  task automatic t_traps;
    logic [7:0] vt [5] = '{8'h00, 8'h05, 8'h04, 8'h03, 8'h22};
    for (int i = 0; i < 5; i++) begin
      cmd(i[3:0], 8'h22);
      rd("trap ip", tem_pkg::OFF_INSTR_PTR, {6'h0, vt[i], 2'h0} ^ 16'h5A5A);
      cmd(tem_pkg::OP_TRAP_RET, 8'h00);
    end
  endtask
  task automatic t_esc;
    for (int i = 0; i < 2; i++) begin
      apb(1'h1, tem_pkg::OFF_ESC_EA, 32'h34 + 32'(2 * i), r);
      cmd(i[0] ? tem_pkg::OP_ESC_B : tem_pkg::OP_ESC_A, 8'h00);
      chk("snoop addr", {12'h0, snoop_addr}, 32'h10034 + 32'(2 * i));
    end
    rd("flags kept", tem_pkg::OFF_FLAGS, 16'h8800);
  endtask
  task automatic t_enter;
    cmd(tem_pkg::OP_ENTER_EMU, 8'h40);
    nm("emu mode", 1'h0);
    rd("seg", tem_pkg::OFF_CODE_SEG, 16'h5B58);
    rd("ip", tem_pkg::OFF_INSTR_PTR, 16'h5B5A);
    rd("sp", tem_pkg::OFF_STACK_PTR, 16'h01FA);
    chk("pushed flags", {16'h0, u_mem.m[20'h001FE]}, 32'h8800);
  endtask
  task automatic t_refuse;
    cmd(tem_pkg::OP_ENTER_EMU, 8'h40);
    rd("nest err", tem_pkg::OFF_STATUS, 16'h0010);
    apb(1'h1, tem_pkg::OFF_STATUS, 32'h10, r);
    cmd(tem_pkg::OP_NCALL, 8'h1F);
    rd("low vec err", tem_pkg::OFF_STATUS, 16'h0010);
    apb(1'h1, tem_pkg::OFF_STATUS, 32'h10, r);
    apb(1'h0, 12'h100, 32'h0, r);
  endtask
  task automatic t_standby;
    cmd(tem_pkg::OP_HALT, 8'h00);
    chk("clk gated", {31'h0, core_clk_en}, 32'h0);
    hold_req <= 1'h1;
    repeat (8) @(posedge pclk);
    chk("hold grant", {31'h0, hold_ack}, 32'h1);
    hold_req <= 1'h0;
    repeat (8) @(posedge pclk);
    chk("standby again", {30'h0, hold_ack, core_clk_en}, 32'h0);
    nmi <= 1'h1;
    repeat (40) @(posedge pclk);
    nmi <= 1'h0;
    nm("nmi native", 1'h1);
    rd("nmi ip", tem_pkg::OFF_INSTR_PTR, 16'h5A52);
    cmd(tem_pkg::OP_TRAP_RET, 8'h00);
    nm("nmi return", 1'h0);
    cmd(tem_pkg::OP_NCALL, 8'h21);
    nm("ncall", 1'h1);
    chk("ncall mode", {16'h0, u_mem.m[20'h001F8]} & 32'h8000, 32'h0);
    cmd(tem_pkg::OP_TRAP_RET, 8'h00);
    nm("tret", 1'h0);
    cmd(tem_pkg::OP_LEAVE_EMU, 8'h00);
    nm("leave", 1'h1);
    rd("sp back", tem_pkg::OFF_STACK_PTR, 16'h0200);
  endtask
  initial begin
    repeat (20000) @(posedge pclk);
    fails++;
    stop_test;
  end
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'h1;
    apb(1'h1, tem_pkg::OFF_STACK_PTR, 32'h200, r);
    apb(1'h1, tem_pkg::OFF_DATA_SEG0, 32'h1000, r);
    apb(1'h1, tem_pkg::OFF_FLAGS, 32'h8800, r);
    t_traps;
    t_esc;
    t_enter;
    t_refuse;
    t_standby;
    stop_test;
  end
endmodule // trap_and_emulation_mode_control_tb
